// ==== rsc_cfg.svh ====
// Register map, reset values, field positions and framing constants
// Functional notes
// - bit 7 picks differential or single input
// - bit 6 puts converter in card-detect mode
// - select field routes signal processing source
// - collision when secondary reaches 1/8, 1/4, 1/2
// - threshold code 3 disables collision reports
// - high-pass corner bits go to amplifier
// - gain bits go to amplifier
// - exponent zero: rate is clock/(mantissa+1)
// - else clock/(mantissa+33)/2^(exponent-1)
// - characters are start, eight data, stop
// - serial speed register resets to 7Ah
// - trim byte goes to slow oscillator
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

// Register indices; byte address is four times the index
`define RSC_IDX_RCV 8'h38
`define RSC_IDX_RX_ANALOG_GAIN_FILTER 8'h39
`define RSC_IDX_SPEED 8'h3B
`define RSC_IDX_TRIM 8'h3C

// Reset values
`define RSC_RST_RCV 8'h00
`define RSC_RST_RX_ANALOG_GAIN_FILTER 8'h00
`define RSC_RST_SPEED 8'h7A
`define RSC_RST_TRIM 8'h00
`define RSC_RST_DIV 13'h00EC // Divisor of the speed reset code, (26 + 33) << 2

// Writable bit masks; cleared bits are reserved
`define RSC_MASK_RCV 8'hF3
`define RSC_MASK_RX_ANALOG_GAIN_FILTER 8'hCF

// Field positions
`define RSC_BIT_SINGLE 7
`define RSC_BIT_ADCMODE 6
`define RSC_SEL_LSB 4
`define RSC_COLL_LSB 0
`define RSC_TRIMF_LSB 6
`define RSC_HPCF_LSB 2
`define RSC_GAIN_LSB 0
`define RSC_EXP_LSB 5

// Baud divider terms, in reference clock cycles per bit
`define RSC_MANT_ADD_LO 13'h0001
`define RSC_MANT_ADD_HI 13'h0021
`define RSC_DIV_W 13

// Character framing: start, data, stop
`define RSC_DATA_BITS 8
`define RSC_FRAME_BITS 10

`endif

// ==== rsc_pkg.sv ====
// Types shared by the receiver and serial clock configuration block
package rsc_pkg;
    typedef enum logic [1:0] {
        SEL_IDLE, SEL_RX_PATH, SEL_ENVELOPE, SEL_GENERIC
    } rsc_sel_t;
    typedef enum logic [1:0] {
        COLL_EIGHTH, COLL_QUARTER, COLL_HALF, COLL_OFF
    } rsc_coll_t;
    typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} rsc_tx_state_t;
endpackage : rsc_pkg

// ==== rsc_uart_tx.sv ====
// Host serial transmitter: baud divider and 8N1 character shifter
`timescale 1ns/1ps
`include "rsc_cfg.svh"
module rsc_uart_tx #(
    parameter int DIV_W = `RSC_DIV_W
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic [7:0] speed_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    output logic txd_o,
    output logic [DIV_W-1:0] divisor_o
);
    import rsc_pkg::*;

    rsc_tx_state_t state_q;
    logic [DIV_W-1:0] div_d;
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] cnt_q;
    logic [`RSC_FRAME_BITS-1:0] shreg_q;
    logic [3:0] bits_q;
    logic [2:0] exp_w;
    logic [DIV_W-1:0] mant_w;

    assign exp_w = speed_i[7:`RSC_EXP_LSB];
    assign mant_w = DIV_W'(speed_i[`RSC_EXP_LSB-1:0]);

    // Reference cycles per bit from exponent and mantissa
    always_comb begin
        if (exp_w == 3'h0) begin
            div_d = mant_w + `RSC_MANT_ADD_LO;
        end else begin
            div_d = (mant_w + `RSC_MANT_ADD_HI) << (exp_w - 3'h1);
        end
    end

    // Divisor register, refreshed every cycle
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            div_q <= DIV_W'(`RSC_RST_DIV); // Matches the speed reset code
        end else begin
            div_q <= div_d;
        end
    end
    assign divisor_o = div_q;

    // Character shifter; a new rate applies from the next bit
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            state_q <= TX_IDLE;
            shreg_q <= '1;
            bits_q <= 4'h0;
            cnt_q <= '0;
            tx_ready_o <= 1'b1;
        end else begin
            unique case (state_q)
                TX_IDLE: begin
                    if (tx_valid_i) begin
                        shreg_q <= {1'b1, tx_data_i, 1'b0};
                        bits_q <= 4'h0;
                        cnt_q <= div_q - 1'b1;
                        tx_ready_o <= 1'b0;
                        state_q <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (cnt_q != '0) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else if (bits_q == 4'(`RSC_FRAME_BITS - 1)) begin
                        shreg_q <= '1;
                        tx_ready_o <= 1'b1;
                        state_q <= TX_IDLE;
                    end else begin
                        shreg_q <= {1'b1, shreg_q[`RSC_FRAME_BITS-1:1]};
                        bits_q <= bits_q + 4'h1;
                        cnt_q <= div_q - 1'b1;
                    end
                end
            endcase
        end
    end

    // Line idles high between characters
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            txd_o <= 1'b1;
        end else if (state_q == TX_IDLE && tx_valid_i) begin
            txd_o <= 1'b0;
        end else if (state_q == TX_SHIFT && cnt_q == '0) begin
            txd_o <= (bits_q == 4'(`RSC_FRAME_BITS - 1)) ? 1'b1 : shreg_q[1];
        end
    end
endmodule : rsc_uart_tx

// ==== rsc_regs.sv ====
// Receiver and serial clock configuration registers on an Avalon-MM slave
`timescale 1ns/1ps
`include "rsc_cfg.svh"
module rsc_regs #(
    parameter int LVL_W = 8
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Avalon-MM slave, word addressed by register index
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Receiver path configuration
    output logic rx_single_input_o,
    output logic converter_mode_sel_o,
    output rsc_pkg::rsc_sel_t proc_input_select_o,
    output rsc_pkg::rsc_coll_t collision_threshold_o,
    // Analog receive amplifier
    output logic [1:0] factory_trim_field_o,
    output logic [1:0] rx_hp_corner_o,
    output logic [1:0] rx_gain_o,
    // Slow oscillator
    output logic [7:0] slow_osc_trim_value_o,
    // Collision decision from decoder strengths
    input wire logic [LVL_W-1:0] main_level_i,
    input wire logic [LVL_W-1:0] second_level_i,
    input wire logic level_valid_i,
    output logic collision_o,
    // Host serial transmit
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    output logic uart_txd_o,
    output logic [`RSC_DIV_W-1:0] baud_divisor_o
);
    import rsc_pkg::*;

    logic [7:0] rcv_q;
    logic [7:0] rx_analog_gain_filter_q;
    logic [7:0] speed_q;
    logic [7:0] trim_q;
    logic wait_q;
    logic [31:0] rdata_q;
    logic coll_q;
    logic wr_en;

    // True when the address selects the given register index
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] idx);
        hit = (addr == idx);
    endfunction : hit

    // Collision decision against the programmed threshold
    function automatic logic coll_hit(
        input logic [1:0] thr,
        input logic [LVL_W-1:0] main_lvl,
        input logic [LVL_W-1:0] sec_lvl
    );
        logic [LVL_W+2:0] sec_x;
        logic [LVL_W+2:0] main_x;
        sec_x = {3'h0, sec_lvl};
        main_x = {3'h0, main_lvl};
        unique case (thr)
            2'h0: coll_hit = (sec_x << 3) >= main_x;
            2'h1: coll_hit = (sec_x << 2) >= main_x;
            2'h2: coll_hit = (sec_x << 1) >= main_x;
            2'h3: coll_hit = 1'b0;
        endcase
    endfunction : coll_hit

    // Write takes effect at the edge the master sees waitrequest low
    assign wr_en = avs_write_i && !wait_q;

    // One wait cycle, then a single acknowledge cycle
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            wait_q <= 1'b1;
        end else if (wait_q && (avs_read_i || avs_write_i)) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    // Read data captured during the wait cycle, held through acknowledge
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (wait_q && avs_read_i) begin
            if (hit(avs_address_i, `RSC_IDX_RCV)) begin
                rdata_q <= {24'h00_0000, rcv_q};
            end else if (hit(avs_address_i, `RSC_IDX_RX_ANALOG_GAIN_FILTER)) begin
                rdata_q <= {24'h00_0000, rx_analog_gain_filter_q};
            end else if (hit(avs_address_i, `RSC_IDX_SPEED)) begin
                rdata_q <= {24'h00_0000, speed_q};
            end else if (hit(avs_address_i, `RSC_IDX_TRIM)) begin
                rdata_q <= {24'h00_0000, trim_q};
            end else begin
                rdata_q <= 32'h0000_0000; // Unmapped reads zero
            end
        end
    end

    // Receiver path configuration register
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            rcv_q <= `RSC_RST_RCV;
        end else if (wr_en && hit(avs_address_i, `RSC_IDX_RCV)) begin
            rcv_q <= avs_writedata_i[7:0] & `RSC_MASK_RCV;
        end
    end

    // Analog gain and filter register
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            rx_analog_gain_filter_q <= `RSC_RST_RX_ANALOG_GAIN_FILTER;
        end else if (wr_en && hit(avs_address_i, `RSC_IDX_RX_ANALOG_GAIN_FILTER)) begin
            rx_analog_gain_filter_q <= avs_writedata_i[7:0] & `RSC_MASK_RX_ANALOG_GAIN_FILTER;
        end
    end

    // Host serial speed register
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            speed_q <= `RSC_RST_SPEED;
        end else if (wr_en && hit(avs_address_i, `RSC_IDX_SPEED)) begin
            speed_q <= avs_writedata_i[7:0];
        end
    end

    // Slow oscillator trim register
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            trim_q <= `RSC_RST_TRIM;
        end else if (wr_en && hit(avs_address_i, `RSC_IDX_TRIM)) begin
            trim_q <= avs_writedata_i[7:0];
        end
    end

    // Collision flag, updated on each valid strength sample
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            coll_q <= 1'b0;
        end else if (rcv_q[`RSC_COLL_LSB +: 2] == 2'h3) begin
            coll_q <= 1'b0;
        end else if (level_valid_i) begin
            coll_q <= coll_hit(rcv_q[`RSC_COLL_LSB +: 2], main_level_i, second_level_i);
        end
    end

    // Bus outputs
    assign avs_waitrequest_o = wait_q;
    assign avs_readdata_o = rdata_q;

    // Configuration fields driven straight from register bits
    assign rx_single_input_o = rcv_q[`RSC_BIT_SINGLE];
    assign converter_mode_sel_o = rcv_q[`RSC_BIT_ADCMODE];
    assign proc_input_select_o = rsc_sel_t'(rcv_q[`RSC_SEL_LSB +: 2]);
    assign collision_threshold_o = rsc_coll_t'(rcv_q[`RSC_COLL_LSB +: 2]);
    assign factory_trim_field_o = rx_analog_gain_filter_q[`RSC_TRIMF_LSB +: 2];
    assign rx_hp_corner_o = rx_analog_gain_filter_q[`RSC_HPCF_LSB +: 2];
    assign rx_gain_o = rx_analog_gain_filter_q[`RSC_GAIN_LSB +: 2];
    assign slow_osc_trim_value_o = trim_q; // larger code, lower frequency
    assign collision_o = coll_q;

    // Host serial transmitter at the programmed rate
    rsc_uart_tx #(
        .DIV_W(`RSC_DIV_W)
    ) u_tx (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .speed_i(speed_q),
        .tx_data_i(tx_data_i),
        .tx_valid_i(tx_valid_i),
        .tx_ready_o(tx_ready_o),
        .txd_o(uart_txd_o),
        .divisor_o(baud_divisor_o)
    );

    // Checks
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);

    property p_rcv_single;
        wr_en && hit(avs_address_i, `RSC_IDX_RCV)
            |=> rx_single_input_o == $past(avs_writedata_i[7]);
    endproperty
    a_rcv_single: assert property (p_rcv_single)
        else $error("input mode bit not applied");

    property p_adc_mode;
        wr_en && hit(avs_address_i, `RSC_IDX_RCV)
            |=> ##1 converter_mode_sel_o == $past(avs_writedata_i[6], 2);
    endproperty
    a_adc_mode: assert property (p_adc_mode)
        else $error("converter mode bit not applied");

    property p_sel;
        wr_en && hit(avs_address_i, `RSC_IDX_RCV) && avs_writedata_i[5:4] == 2'h2
            |=> proc_input_select_o == SEL_ENVELOPE;
    endproperty
    a_sel: assert property (p_sel)
        else $error("input select not applied");

    property p_coll_eighth;
        level_valid_i && rcv_q[1:0] == 2'h0
            && ({3'h0, second_level_i} << 3) >= {3'h0, main_level_i}
            |=> collision_o;
    endproperty
    a_coll_eighth: assert property (p_coll_eighth)
        else $error("collision at one eighth missed");

    property p_coll_off;
        rcv_q[1:0] == 2'h3 [*2] |-> !collision_o;
    endproperty
    a_coll_off: assert property (p_coll_off)
        else $error("collision reported while switched off");

    property p_div_lin;
        $stable(speed_q) && speed_q[7:5] == 3'h0
            |-> baud_divisor_o == 13'(speed_q[4:0]) + 13'h0001;
    endproperty
    a_div_lin: assert property (p_div_lin)
        else $error("linear divisor wrong");

    property p_div_exp;
        $stable(speed_q) && speed_q[7:5] != 3'h0
            |-> baud_divisor_o
                == (13'(speed_q[4:0]) + 13'h0021) << (speed_q[7:5] - 3'h1);
    endproperty
    a_div_exp: assert property (p_div_exp)
        else $error("exponent divisor wrong");

    property p_speed_rst;
        @(posedge sys_clk_i) disable iff (1'b0)
            !rstn_i |=> speed_q == `RSC_RST_SPEED && rcv_q == `RSC_RST_RCV;
    endproperty
    a_speed_rst: assert property (p_speed_rst)
        else $error("reset value wrong");

    property p_rsvd;
        !avs_waitrequest_o && avs_read_i && hit(avs_address_i, `RSC_IDX_RX_ANALOG_GAIN_FILTER)
            |-> avs_readdata_o[31:8] == 24'h0 && avs_readdata_o[5:4] == 2'h0;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bits read nonzero");

    property p_ack_one;
        !avs_waitrequest_o |=> avs_waitrequest_o;
    endproperty
    a_ack_one: assert property (p_ack_one) // Single-cycle acknowledge
        else $error("acknowledge longer than one cycle");

    property p_coll_quarter;
        level_valid_i && rcv_q[1:0] == 2'h1
            && ({3'h0, second_level_i} << 2) >= {3'h0, main_level_i}
            |=> collision_o;
    endproperty
    a_coll_quarter: assert property (p_coll_quarter)
        else $error("collision at one quarter missed");

    property p_coll_half;
        level_valid_i && rcv_q[1:0] == 2'h2
            && ({3'h0, second_level_i} << 1) >= {3'h0, main_level_i}
            |=> collision_o;
    endproperty
    a_coll_half: assert property (p_coll_half)
        else $error("collision at one half missed");

    property p_coll_below;
        level_valid_i && rcv_q[1:0] != 2'h3
            && ({3'h0, second_level_i} << 3) < {3'h0, main_level_i}
            |=> !collision_o;
    endproperty
    a_coll_below: assert property (p_coll_below)
        else $error("collision flagged below every threshold");

    property p_hpcf;
        wr_en && hit(avs_address_i, `RSC_IDX_RX_ANALOG_GAIN_FILTER)
            |=> rx_hp_corner_o == $past(avs_writedata_i[3:2]);
    endproperty
    a_hpcf: assert property (p_hpcf)
        else $error("high-pass corner not forwarded");

    property p_gain;
        wr_en && hit(avs_address_i, `RSC_IDX_RX_ANALOG_GAIN_FILTER)
            |=> rx_gain_o == $past(avs_writedata_i[1:0]);
    endproperty
    a_gain: assert property (p_gain)
        else $error("gain step not forwarded");

    property p_trim_fwd;
        wr_en && hit(avs_address_i, `RSC_IDX_TRIM)
            |=> slow_osc_trim_value_o == $past(avs_writedata_i[7:0]);
    endproperty
    a_trim_fwd: assert property (p_trim_fwd)
        else $error("oscillator trim not forwarded");

    property p_rsvd_rcv;
        !avs_waitrequest_o && avs_read_i && hit(avs_address_i, `RSC_IDX_RCV)
            |-> avs_readdata_o[31:8] == 24'h0 && avs_readdata_o[3:2] == 2'h0;
    endproperty
    a_rsvd_rcv: assert property (p_rsvd_rcv)
        else $error("reserved receiver bits read nonzero");

    property p_tx_start;
        tx_valid_i && tx_ready_o |=> !uart_txd_o && !tx_ready_o;
    endproperty
    a_tx_start: assert property (p_tx_start)
        else $error("start bit not sent on take");

    c_write_speed: cover property (wr_en && hit(avs_address_i, `RSC_IDX_SPEED));
    c_collision: cover property (level_valid_i ##1 collision_o);
    c_tx_char: cover property ($fell(tx_ready_o) ##[1:1000] $rose(tx_ready_o));
    c_read_rcv: cover property (!wait_q && avs_read_i
        && hit(avs_address_i, `RSC_IDX_RCV));
endmodule : rsc_regs

// ==== rsc_host_model.sv ====
// Host controller model: 8N1 receiver watching the device serial line
`timescale 1ns/1ps
module rsc_host_model (
    input wire logic sys_clk_i,
    input wire logic rxd_i,
    input wire logic [12:0] divisor_i,
    output logic [7:0] byte_o,
    output logic [7:0] count_o,
    output logic frame_ok_o
);
    logic [7:0] shift_q;
    int div_n;
    // Mid-bit sampling: start low, data LSB first, stop high
    initial begin
        count_o = 8'h00;
        frame_ok_o = 1'b1;
        byte_o = 8'h00;
        forever begin
            @(negedge rxd_i);
            div_n = int'(divisor_i);
            repeat (div_n / 2) @(posedge sys_clk_i);
            if (rxd_i !== 1'b0) frame_ok_o = 1'b0;
            for (int i = 0; i < 8; i++) begin
                repeat (div_n) @(posedge sys_clk_i);
                shift_q[i] = rxd_i;
            end
            repeat (div_n) @(posedge sys_clk_i);
            if (rxd_i !== 1'b1) frame_ok_o = 1'b0;
            byte_o = shift_q;
            count_o = count_o + 8'h01;
        end
    end
endmodule : rsc_host_model

// ==== rx_and_serial_clock_config_test.sv ====
// Self-checking bench for the receiver and serial clock registers
`timescale 1ns/1ps
`include "rsc_cfg.svh"
module rx_and_serial_clock_config_test;
    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic waitreq;
    logic single_in, conv_mode, tx_ready, txd, coll;
    rsc_pkg::rsc_sel_t sel;
    rsc_pkg::rsc_coll_t thr;
    logic [1:0] ftrim, hpcf, gain;
    logic [7:0] lfo, main_lvl = 8'h00, sec_lvl = 8'h00, tx_data = 8'h00;
    logic lvl_valid = 1'b0;
    logic tx_valid = 1'b0;
    logic [`RSC_DIV_W-1:0] divisor;
    logic [7:0] rx_byte, rx_count;
    logic rx_ok;
    logic [31:0] got;
    int error_cnt = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [7:0] codes [12] = '{8'hFA, 8'hEB, 8'hDA, 8'hCB, 8'hAB, 8'h9A,
                               8'h7A, 8'h74, 8'h5A, 8'h3A, 8'h10, 8'h15};

    rsc_regs rsc_regs_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
        .rx_single_input_o(single_in), .converter_mode_sel_o(conv_mode),
        .proc_input_select_o(sel), .collision_threshold_o(thr),
        .factory_trim_field_o(ftrim), .rx_hp_corner_o(hpcf), .rx_gain_o(gain),
        .slow_osc_trim_value_o(lfo), .main_level_i(main_lvl), .second_level_i(sec_lvl),
        .level_valid_i(lvl_valid), .collision_o(coll), .tx_data_i(tx_data),
        .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .uart_txd_o(txd),
        .baud_divisor_o(divisor));
    rsc_host_model rsc_host_model_inst (.sys_clk_i(sys_clk_i), .rxd_i(txd),
        .divisor_i(divisor), .byte_o(rx_byte), .count_o(rx_count), .frame_ok_o(rx_ok));

    // 10 MHz clock
    initial begin
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    // Hang guard
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic summarize();
        if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Avalon access held until waitrequest is sampled low
    task automatic bus(input logic is_wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr <= a;
        wdata <= {24'h0, d};
        wr <= is_wr;
        rd <= ~is_wr;
        do @(posedge sys_clk_i); while (waitreq !== 1'b0);
        got = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus

    task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(name, got, {24'h0, exp});
    endtask : rchk

    // Expected cycles per bit from a speed code
    function automatic logic [31:0] ref_div(input logic [7:0] s);
        if (s[7:5] == 3'h0) return 32'(s[4:0]) + 32'h1;
        return (32'(s[4:0]) + 32'h21) << (s[7:5] - 3'h1);
    endfunction : ref_div

    // One strength sample, collision seen the cycle after
    task automatic sample(input logic [7:0] m, input logic [7:0] s, input logic exp);
        @(posedge sys_clk_i);
        main_lvl <= m;
        sec_lvl <= s;
        lvl_valid <= 1'b1;
        @(posedge sys_clk_i);
        lvl_valid <= 1'b0;
        @(posedge sys_clk_i);
        chk("collision", coll, exp);
    endtask : sample

    task automatic send(input logic [7:0] b);
        do @(posedge sys_clk_i); while (tx_ready !== 1'b1);
        tx_data <= b;
        tx_valid <= 1'b1;
        @(posedge sys_clk_i);
        tx_valid <= 1'b0;
    endtask : send

    // Main sequence
    initial begin
        repeat (2) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        rchk("rcv_rst", `RSC_IDX_RCV, 8'h00);
        rchk("rx_analog_gain_filter_rst", `RSC_IDX_RX_ANALOG_GAIN_FILTER, 8'h00);
        rchk("speed_rst", `RSC_IDX_SPEED, 8'h7A);
        rchk("trim_rst", `RSC_IDX_TRIM, 8'h00);
        chk("div_rst", divisor, ref_div(8'h7A));
        bus(1'b1, `RSC_IDX_RCV, 8'hFF);
        rchk("rcv_rsv", `RSC_IDX_RCV, 8'hF3);
        chk("coll_off", thr, 32'h3);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, `RSC_IDX_RCV, 8'((i << 4) | (i[0] << 7) | (i[1] << 6)));
            @(posedge sys_clk_i);
            chk("single", single_in, i[0]);
            chk("adcmode", conv_mode, i[1]);
            chk("insel", sel, i);
        end
        bus(1'b1, `RSC_IDX_RX_ANALOG_GAIN_FILTER, 8'h3F); // factory trim kept zero
        rchk("rx_analog_gain_filter_rsv", `RSC_IDX_RX_ANALOG_GAIN_FILTER, 8'h0F);
        bus(1'b1, `RSC_IDX_RX_ANALOG_GAIN_FILTER, 8'h09); // factory trim kept zero
        @(posedge sys_clk_i);
        chk("hpcf", hpcf, 32'h2);
        chk("gain", gain, 32'h1);
        chk("ftrim", ftrim, 32'h0);
        bus(1'b1, `RSC_IDX_TRIM, 8'hA5);
        rchk("trim", `RSC_IDX_TRIM, 8'hA5);
        chk("lfo", lfo, 32'hA5);
        bus(1'b1, 8'h3A, 8'hFF);
        rchk("unmapped", 8'h3A, 8'h00);
        // Threshold boundaries at main strength 80
        for (int t = 0; t < 3; t++) begin
            bus(1'b1, `RSC_IDX_RCV, 8'(t));
            sample(8'd80, 8'(80 >> (3 - t)), 1'b1);
            sample(8'd80, 8'(80 >> (3 - t)) - 8'd1, 1'b0);
        end
        sample(8'd80, 8'd40, 1'b1);
        bus(1'b1, `RSC_IDX_RCV, 8'h03);
        repeat (2) @(posedge sys_clk_i);
        chk("coll_clear", coll, 32'h0);
        sample(8'd80, 8'hFF, 1'b0);
        // Typical host codes, none above the top rate
        foreach (codes[k]) begin
            bus(1'b1, `RSC_IDX_SPEED, codes[k]);
            repeat (2) @(posedge sys_clk_i);
            chk("divisor", divisor, ref_div(codes[k]));
        end
        bus(1'b1, `RSC_IDX_SPEED, 8'h1C);
        repeat (2) @(posedge sys_clk_i);
        chk("div_exp0", divisor, 32'd29);
        // Two characters back to back
        send(8'hA5);
        @(posedge sys_clk_i);
        chk("tx_busy", tx_ready, 32'h0);
        send(8'h3C);
        while (rx_count !== 8'd1) @(posedge sys_clk_i);
        chk("byte0", rx_byte, 32'hA5);
        while (rx_count !== 8'd2) @(posedge sys_clk_i);
        chk("byte1", rx_byte, 32'h3C);
        chk("framing", rx_ok, 32'h1);
        summarize();
    end
endmodule : rx_and_serial_clock_config_test
